// file: hw/phml_mailbox.sv
// phml_mailbox: host target window, mailbox, config regs and boot loader
//
// Behaviour
// - legacy audio config word at 40H is read/write, resets to 907FH.
// - legacy disable bit 15 set turns off all legacy audio functions.
// - bit 2 enables game port at the joystick base address.
// - 16-byte window decoded from memory base or I/O base.
// - every host write in the window pushes its lowest enabled byte to processor FIFO unless the FIFO is full.
// - write to offset 2 drives bit 0 to serial clock, bit 1 to data.
// - host reads data byte at offset 0, status byte at offset 1.
// - processor data write raises host interrupt; host data read drops it.
// - status bit 7 reads 0 while data pending, 1 after read.
// - status bit 6 is 1 when processor FIFO full, else 0.
// - status bits 5:3 give processor data type; bits 2:0 read zero.
// - after reset release read eeprom bytes 0 to 31 into registers.
// - loaded values accepted only when first bytes are 55H then AAH.
// - bytes 2-9 ids, 0AH cap id, 0BH next, 10H bse, 11H data.
// - byte 0EH fills pmcsr bits 7:2, byte 0FH high bits 6:5 only.
// - loader serial clock is the bus clock divided by 1024.
// - whole automatic read spans 316 serial clock cycles.
// - pll source is bus clock/3 in reset or no codec clock, else codec.
// - processor may enter soft power-down, system clock divided by 32.
// - after reset release processor boots from internal ROM.
// - subsystem ids read zero without valid eeprom, else bytes 6-9.
`timescale 1ns/10ps
`default_nettype none
module phml_mailbox #(
  parameter logic [15:0] VENDOR_DEF = 16'h1AB5, // arbitrary value
  parameter logic [15:0] DEVICE_DEF = 16'h0C35  // arbitrary value
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // decoded bus target access
  input  wire logic        tgt_req,
  input  wire logic        tgt_cfg,
  input  wire logic        tgt_io,
  input  wire logic        tgt_we,
  input  wire logic [31:0] tgt_addr,
  input  wire logic [3:0]  tgt_be,
  input  wire logic [31:0] tgt_wdata,
  output logic             tgt_hit,
  output logic             tgt_ack,
  output logic [31:0]      tgt_rdata,
  output logic             host_int_req,
  // control processor side
  output logic             cp_fifo_wr,
  output logic [7:0]       cp_fifo_wdata,
  input  wire logic        cp_fifo_full,
  input  wire logic        cp_data_we,
  input  wire logic [7:0]  cp_data,
  input  wire logic        cp_type_we,
  input  wire logic [2:0]  cp_type,
  input  wire logic        cp_pdn_req,
  output logic             cp_boot_rom_start,
  output logic             sysclk_div32,
  // clocking
  input  wire logic        codec_master_clock_in_det,
  output logic             pll_sel_codec,
  // legacy functions
  output logic             legacy_audio_en,
  output logic             game_port_enable,
  output logic [15:0]      game_port_base,
  // serial eeprom pins
  output logic             ee_scl,
  input  wire logic        ee_sda_i,
  output logic             ee_sda_o,
  output logic             ee_sda_oe_n,
  output logic             ee_load_busy,
  output logic             ee_id_valid
);

  // ==========================================================
  // state
  typedef struct packed {
    logic [15:0]           legacy;
    logic [15:0]           joy;
    logic [2:0]            cmd;
    logic [27:0]           membar;
    logic [27:0]           iobar;
    logic [7:0]            intline;
    logic [1:0]            pstate;
    logic                  pending;
    logic [2:0]            dtype;
    logic [7:0]            hdata;
    logic                  bb_scl;
    logic                  bb_sda;
    logic                  fifo_wr;
    logic [7:0]            fifo_wd;
    logic                  ack;
    logic [31:0]           rdata;
    logic [31:0][7:0]      shadow;
    logic                  ee_valid;
    logic                  sda_s1;
    logic                  sda_s2;
    logic                  ck_s1;
    logic                  ck_s2;
    logic                  pll_codec;
    logic                  pdn;
    logic                  boot_pend;
    logic                  boot_pulse;
  } phml_mb_t;

  phml_mb_t r, n;

  logic        ld_scl;
  logic        ld_low;
  logic        ld_busy;
  logic        ld_vld;
  logic [4:0]  ld_addr;
  logic [7:0]  ld_data;
  logic        ld_done;

  // ==========================================================
  // boot image loader
  phml_ee_loader u_loader (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .start     (r.boot_pulse),
    .sda_in    (r.sda_s2),
    .scl       (ld_scl),
    .sda_low   (ld_low),
    .busy      (ld_busy),
    .byte_vld  (ld_vld),
    .byte_addr (ld_addr),
    .byte_data (ld_data),
    .done      (ld_done)
  );

  // ==========================================================
  // helpers
  function automatic logic [31:0] bmerge(input logic [31:0] o,
                                         input logic [31:0] w,
                                         input logic [3:0]  be);
    logic [31:0] v;
    v = o;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        v[i*8 +: 8] = w[i*8 +: 8];
      end
    end
    return v;
  endfunction

  // lowest enabled byte lane of an access
  function automatic logic [1:0] low_lane(input logic [3:0] be);
    logic [1:0] l;
    l = 2'd3;
    for (int i = 3; i >= 0; i--) begin
      if (be[i]) begin
        l = 2'(i);
      end
    end
    return l;
  endfunction

  // ==========================================================
  // identity values: image only once signature is good
  logic [15:0] id_ven;
  logic [15:0] id_dev;
  logic [15:0] id_ssv;
  logic [15:0] id_ssd;
  logic [7:0]  pm_id;
  logic [7:0]  pm_next;
  logic [7:0]  pm_lo;
  logic [7:0]  pm_hi;
  logic [7:0]  pm_bse;
  logic [7:0]  pm_data;
  logic [7:0]  cap_ptr;

  always_comb begin
    id_ven  = VENDOR_DEF;
    id_dev  = DEVICE_DEF;
    id_ssv  = 16'h0000;
    id_ssd  = 16'h0000;
    pm_id   = phml_pkg::PM_ID_DEF;
    pm_next = 8'h00;
    pm_lo   = 8'h00;
    pm_hi   = 8'h00;
    pm_bse  = 8'h00;
    pm_data = 8'h00;
    cap_ptr = 8'h00;
    if (r.ee_valid) begin
      id_ven  = {r.shadow[phml_pkg::EE_VEN+1], r.shadow[phml_pkg::EE_VEN]};
      id_dev  = {r.shadow[phml_pkg::EE_DEV+1], r.shadow[phml_pkg::EE_DEV]};
      id_ssv  = {r.shadow[phml_pkg::EE_SSV+1], r.shadow[phml_pkg::EE_SSV]};
      id_ssd  = {r.shadow[phml_pkg::EE_SSD+1], r.shadow[phml_pkg::EE_SSD]};
      pm_id   = r.shadow[phml_pkg::EE_CAPID];
      pm_next = r.shadow[phml_pkg::EE_NEXT];
      pm_lo   = r.shadow[phml_pkg::EE_PMLO] & phml_pkg::PMLO_MASK;
      pm_hi   = r.shadow[phml_pkg::EE_PMHI] & phml_pkg::PMHI_MASK;
      pm_bse  = r.shadow[phml_pkg::EE_BSE];
      pm_data = r.shadow[phml_pkg::EE_PMDATA];
      cap_ptr = phml_pkg::CAP_PTR_VAL;
    end
  end

  // ==========================================================
  // window decode
  logic        mem_hit;
  logic        io_hit;
  logic        win_hit;
  logic [1:0]  lane;
  logic [3:0]  win_off;
  logic [7:0]  win_byte;
  logic [7:0]  status;

  assign mem_hit = tgt_req && !tgt_cfg && !tgt_io && r.cmd[1]
                   && (tgt_addr[31:4] == r.membar);
  assign io_hit  = tgt_req && !tgt_cfg && tgt_io && r.cmd[0]
                   && (tgt_addr[31:4] == r.iobar);
  assign win_hit  = mem_hit || io_hit;
  assign lane     = low_lane(tgt_be);
  assign win_off  = {tgt_addr[3:2], lane};
  assign win_byte = tgt_wdata[8*lane +: 8];
  assign status   = {!r.pending, cp_fifo_full, r.dtype, 3'b000};
  assign tgt_hit  = (tgt_req && tgt_cfg) || win_hit;

  // ==========================================================
  // configuration read mux
  logic [31:0] cfg_q;

  always_comb begin
    cfg_q = 32'h0000_0000;
    case ({tgt_addr[7:2], 2'b00})
      phml_pkg::CFG_ID:     cfg_q = {id_dev, id_ven};
      phml_pkg::CFG_CMD:    cfg_q = {phml_pkg::STATUS_VAL, 13'h0000, r.cmd};
      phml_pkg::CFG_CLASS:  cfg_q = {phml_pkg::CLASS_VAL, 8'h00};
      phml_pkg::CFG_MEMBAR: cfg_q = {r.membar, phml_pkg::MEMBAR_LOW};
      phml_pkg::CFG_IOBAR:  cfg_q = {r.iobar, phml_pkg::IOBAR_LOW};
      phml_pkg::CFG_SUBSYS: cfg_q = {id_ssd, id_ssv};
      phml_pkg::CFG_CAPPTR: cfg_q = {24'h000000, cap_ptr};
      phml_pkg::CFG_INTR:   cfg_q = {16'h0000, phml_pkg::INT_PIN_VAL,
                                     r.intline};
      phml_pkg::CFG_LEGACY: cfg_q = {16'h0000, r.legacy};
      phml_pkg::CFG_JOY:    cfg_q = {16'h0000, r.joy};
      phml_pkg::CFG_PMCAP:  cfg_q = {16'h0000, pm_next, pm_id};
      phml_pkg::CFG_PMCSR:  cfg_q = {pm_data, pm_bse, pm_hi,
                                     pm_lo | {6'h00, r.pstate}};
      default:              cfg_q = 32'h0000_0000;
    endcase
  end

  // ==========================================================
  // next state
  logic [31:0] wm;

  always_comb begin
    wm = 32'h0000_0000;
    n = r;
    n.fifo_wr = 1'b0;
    n.ack = 1'b0;
    n.boot_pulse = 1'b0;
    n.sda_s1 = ee_sda_i;
    n.sda_s2 = r.sda_s1;
    n.ck_s1 = codec_master_clock_in_det;
    n.ck_s2 = r.ck_s1;
    n.pll_codec = r.ck_s2;
    n.pdn = cp_pdn_req;

    // first cycle after reset release starts loader and boot ROM
    if (r.boot_pend) begin
      n.boot_pend = 1'b0;
      n.boot_pulse = 1'b1;
      n.ee_valid = 1'b0;
    end

    if (cp_type_we) begin
      n.dtype = cp_type;
    end
    if (cp_data_we) begin
      n.hdata = cp_data;
    end

    if (tgt_hit) begin
      n.ack = 1'b1;
      n.rdata = 32'h0000_0000;
    end

    // configuration access
    if (tgt_req && tgt_cfg) begin
      if (!tgt_we) begin
        n.rdata = cfg_q;
      end else begin
        case ({tgt_addr[7:2], 2'b00})
          phml_pkg::CFG_CMD: begin
            wm = bmerge({29'h0, r.cmd}, tgt_wdata, tgt_be);
            n.cmd = wm[2:0];
          end
          phml_pkg::CFG_MEMBAR: begin
            wm = bmerge({r.membar, 4'h0}, tgt_wdata, tgt_be);
            n.membar = wm[31:4];
          end
          phml_pkg::CFG_IOBAR: begin
            wm = bmerge({r.iobar, 4'h0}, tgt_wdata, tgt_be);
            n.iobar = wm[31:4];
          end
          phml_pkg::CFG_INTR: begin
            wm = bmerge({24'h0, r.intline}, tgt_wdata, tgt_be);
            n.intline = wm[7:0];
          end
          phml_pkg::CFG_LEGACY: begin
            wm = bmerge({16'h0, r.legacy}, tgt_wdata, tgt_be);
            n.legacy = wm[15:0];
          end
          phml_pkg::CFG_JOY: begin
            wm = bmerge({16'h0, r.joy}, tgt_wdata, tgt_be);
            n.joy = wm[15:0];
          end
          phml_pkg::CFG_PMCSR: begin
            wm = bmerge({30'h0, r.pstate}, tgt_wdata, tgt_be);
            n.pstate = wm[1:0];
          end
          default: begin
            wm = 32'h0000_0000;
          end
        endcase
      end
    end

    // window access
    if (win_hit && |tgt_be) begin
      if (tgt_we) begin
        // a full fifo cannot take the byte; software polls bit 6 first
        if (!cp_fifo_full) begin
          n.fifo_wr = 1'b1;
          n.fifo_wd = win_byte;
        end
        if (tgt_addr[3:2] == 2'b00 && tgt_be[phml_pkg::WIN_BITBANG[1:0]]) begin
          n.bb_scl = tgt_wdata[16 + phml_pkg::BB_SCL_BIT];
          n.bb_sda = tgt_wdata[16 + phml_pkg::BB_SDA_BIT];
        end
      end else if (tgt_addr[3:2] == 2'b00) begin
        n.rdata = {16'h0000, status, r.hdata};
        if (tgt_be[phml_pkg::WIN_DATA[1:0]]) begin
          n.pending = 1'b0;
        end
      end
    end

    // a new processor word wins over a host read in the same cycle
    if (cp_data_we) begin
      n.pending = 1'b1;
    end

    if (ld_vld) begin
      n.shadow[ld_addr] = ld_data;
    end
    if (ld_done) begin
      n.ee_valid = (r.shadow[0] == phml_pkg::EE_SIG0)
                   && (r.shadow[1] == phml_pkg::EE_SIG1);
    end
    if (win_off == phml_pkg::WIN_STATUS) begin
      wm = wm;
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      r <= '{legacy: phml_pkg::LEGACY_RST, joy: phml_pkg::JOY_RST,
             bb_scl: 1'b1, bb_sda: 1'b1, sda_s1: 1'b1, sda_s2: 1'b1,
             boot_pend: 1'b1, default: '0};
    end else begin
      r <= n;
    end
  end

  // ==========================================================
  // outputs
  assign tgt_ack           = r.ack;
  assign tgt_rdata         = r.rdata;
  assign host_int_req      = r.pending;
  assign cp_fifo_wr        = r.fifo_wr;
  assign cp_fifo_wdata     = r.fifo_wd;
  assign cp_boot_rom_start = r.boot_pulse;
  assign sysclk_div32      = r.pdn;
  assign pll_sel_codec     = r.pll_codec;
  assign legacy_audio_en   = !r.legacy[phml_pkg::LEG_OFF_BIT];
  assign game_port_enable  = r.legacy[phml_pkg::GAME_EN_BIT]
                             && !r.legacy[phml_pkg::LEG_OFF_BIT];
  assign game_port_base    = r.joy;
  // loader owns the pins while it runs; host bit-banging waits
  assign ee_scl            = ld_busy ? ld_scl : r.bb_scl;
  assign ee_sda_o          = 1'b0;
  assign ee_sda_oe_n       = ld_busy ? !ld_low : r.bb_sda;
  assign ee_load_busy      = ld_busy;
  assign ee_id_valid       = r.ee_valid;

endmodule
`default_nettype wire

// file: common/phml_pkg.sv
// phml_pkg: shared constants and types for the host mailbox and loader
package phml_pkg;

  // ==========================================================
  // host window offsets (byte offset inside the 16-byte window)
  localparam logic [3:0]  WIN_DATA     = 4'h0;
  localparam logic [3:0]  WIN_STATUS   = 4'h1;
  localparam logic [3:0]  WIN_BITBANG  = 4'h2;
  localparam int          BB_SCL_BIT   = 0;
  localparam int          BB_SDA_BIT   = 1;

  // ==========================================================
  // configuration space offsets
  localparam logic [7:0]  CFG_ID       = 8'h00;
  localparam logic [7:0]  CFG_CMD      = 8'h04;
  localparam logic [7:0]  CFG_CLASS    = 8'h08;
  localparam logic [7:0]  CFG_MEMBAR   = 8'h10;
  localparam logic [7:0]  CFG_IOBAR    = 8'h14;
  localparam logic [7:0]  CFG_SUBSYS   = 8'h2C;
  localparam logic [7:0]  CFG_CAPPTR   = 8'h34;
  localparam logic [7:0]  CFG_INTR     = 8'h3C;
  localparam logic [7:0]  CFG_LEGACY   = 8'h40;
  localparam logic [7:0]  CFG_JOY      = 8'h64;
  localparam logic [7:0]  CFG_PMCAP    = 8'h80;
  localparam logic [7:0]  CFG_PMCSR    = 8'h84;

  // ==========================================================
  // reset and fixed values
  localparam logic [15:0] LEGACY_RST   = 16'h907F;
  localparam int          LEG_OFF_BIT  = 15;
  localparam int          GAME_EN_BIT  = 2;
  localparam logic [15:0] JOY_RST      = 16'h0200;
  localparam logic [15:0] STATUS_VAL   = 16'h0200;
  localparam logic [23:0] CLASS_VAL    = 24'h040100;
  localparam logic [7:0]  INT_PIN_VAL  = 8'h01;
  localparam logic [7:0]  CAP_PTR_VAL  = 8'h80;
  localparam logic [3:0]  MEMBAR_LOW   = 4'h0;
  localparam logic [3:0]  IOBAR_LOW    = 4'h1;
  localparam logic [7:0]  PM_ID_DEF    = 8'h01;

  // ==========================================================
  // eeprom image layout
  localparam int          EE_BYTES     = 32;
  localparam logic [7:0]  EE_SIG0      = 8'h55;
  localparam logic [7:0]  EE_SIG1      = 8'hAA;
  localparam int          EE_VEN       = 2;
  localparam int          EE_DEV       = 4;
  localparam int          EE_SSV       = 6;
  localparam int          EE_SSD       = 8;
  localparam int          EE_CAPID     = 10;
  localparam int          EE_NEXT      = 11;
  localparam int          EE_PMLO      = 14;
  localparam int          EE_PMHI      = 15;
  localparam int          EE_BSE       = 16;
  localparam int          EE_PMDATA    = 17;
  localparam logic [7:0]  PMLO_MASK    = 8'hFC;
  localparam logic [7:0]  PMHI_MASK    = 8'h60;

  // ==========================================================
  // serial loader timing: one serial clock per EE_DIV clk cycles
  localparam int          EE_DIV       = 1024;
  localparam int          EE_QTR       = EE_DIV / 4;
  localparam logic [9:0]  EE_Q1_C      = 10'(EE_QTR);
  localparam logic [9:0]  EE_HALF_C    = 10'(2 * EE_QTR);
  localparam logic [9:0]  EE_Q3_C      = 10'(3 * EE_QTR);
  localparam logic [9:0]  EE_QEND_C    = 10'(EE_QTR - 1);
  localparam logic [9:0]  EE_LAST_C    = 10'(EE_DIV - 1);
  localparam int          EE_SCL_CYC   = 316;
  localparam logic [7:0]  EE_DEV_WR    = 8'hA0;
  localparam logic [7:0]  EE_DEV_RD    = 8'hA1;
  localparam logic [7:0]  EE_WORD0     = 8'h00;
  localparam logic [5:0]  EE_FIRST_RD  = 6'd3;
  localparam logic [5:0]  EE_LAST_BYT  = 6'(3 + EE_BYTES - 1);

  typedef enum logic [2:0] {
    LD_IDLE, LD_START, LD_BIT, LD_RESTART, LD_STOP
  } phml_ld_st_t;

endpackage

// file: hw/phml_ee_loader.sv
// phml_ee_loader: two-wire sequential reader of the 32-byte boot image
`timescale 1ns/10ps
`default_nettype none
module phml_ee_loader (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       start,
  input  wire logic       sda_in,
  output logic            scl,
  output logic            sda_low,
  output logic            busy,
  output logic            byte_vld,
  output logic [4:0]      byte_addr,
  output logic [7:0]      byte_data,
  output logic            done
);

  typedef struct packed {
    phml_pkg::phml_ld_st_t st;
    logic [9:0]            cnt;
    logic [3:0]            bitn;
    logic [5:0]            byt;
    logic [7:0]            sh;
    logic                  scl;
    logic                  low;
    logic                  vld;
    logic [4:0]            addr;
    logic [7:0]            data;
    logic                  done;
  } phml_ld_t;

  phml_ld_t r, n;
  logic [7:0] cur;

  always_comb begin
    cur = 8'h00;
    n = r;
    n.vld = 1'b0;
    n.done = 1'b0;
    n.cnt = r.cnt + 10'd1;
    case (r.byt)
      6'd0:    cur = phml_pkg::EE_DEV_WR;
      6'd1:    cur = phml_pkg::EE_WORD0;
      default: cur = phml_pkg::EE_DEV_RD;
    endcase
    case (r.st)
      phml_pkg::LD_IDLE: begin
        n.cnt = 10'd0;
        n.scl = 1'b1;
        n.low = 1'b0;
        if (start) begin
          n.st = phml_pkg::LD_START;
        end
      end
      // start: data falls while clock stays high
      phml_pkg::LD_START: begin
        n.low = 1'b1;
        if (r.cnt == phml_pkg::EE_QEND_C) begin
          // clock falls before data moves, so no false stop is seen
          n.scl = 1'b0;
          n.st = phml_pkg::LD_BIT;
          n.cnt = 10'd0;
          n.bitn = 4'd0;
          n.byt = 6'd0;
        end
      end
      phml_pkg::LD_BIT: begin
        n.scl = (n.cnt >= phml_pkg::EE_HALF_C);
        if (r.byt < phml_pkg::EE_FIRST_RD) begin
          n.low = (r.bitn < 4'd8) && !cur[3'(4'd7 - r.bitn)];
        end else begin
          // ack every byte but the last, which gets no ack
          n.low = (r.bitn == 4'd8) && (r.byt != phml_pkg::EE_LAST_BYT);
        end
        if (r.cnt == phml_pkg::EE_Q3_C && r.byt >= phml_pkg::EE_FIRST_RD
            && r.bitn < 4'd8) begin
          n.sh = {r.sh[6:0], sda_in};
          if (r.bitn == 4'd7) begin
            n.vld = 1'b1;
            n.addr = 5'(r.byt - phml_pkg::EE_FIRST_RD);
            n.data = {r.sh[6:0], sda_in};
          end
        end
        if (r.cnt == phml_pkg::EE_LAST_C) begin
          if (r.bitn == 4'd8) begin
            n.bitn = 4'd0;
            n.byt = r.byt + 6'd1;
            if (r.byt == 6'd1) begin
              n.st = phml_pkg::LD_RESTART;
            end else if (r.byt == phml_pkg::EE_LAST_BYT) begin
              n.st = phml_pkg::LD_STOP;
            end
          end else begin
            n.bitn = r.bitn + 4'd1;
          end
        end
      end
      // repeated start: one full serial clock, data falls late in high
      phml_pkg::LD_RESTART: begin
        n.scl = (n.cnt >= phml_pkg::EE_HALF_C);
        // data held low through the clock's fall at the slot end
        n.low = (n.cnt >= phml_pkg::EE_Q3_C) || (n.cnt == 10'd0);
        if (r.cnt == phml_pkg::EE_LAST_C) begin
          n.st = phml_pkg::LD_BIT;
        end
      end
      phml_pkg::LD_STOP: begin
        n.scl = (n.cnt >= phml_pkg::EE_Q1_C);
        n.low = (n.cnt < phml_pkg::EE_HALF_C);
        if (r.cnt == phml_pkg::EE_LAST_C) begin
          n.st = phml_pkg::LD_IDLE;
          n.scl = 1'b1;
          n.low = 1'b0;
          n.done = 1'b1;
        end
      end
      default: begin
        n.st = phml_pkg::LD_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      r <= '{st: phml_pkg::LD_IDLE, scl: 1'b1, default: '0};
    end else begin
      r <= n;
    end
  end

  assign scl       = r.scl;
  assign sda_low   = r.low;
  assign busy      = (r.st != phml_pkg::LD_IDLE);
  assign byte_vld  = r.vld;
  assign byte_addr = r.addr;
  assign byte_data = r.data;
  assign done      = r.done;

endmodule
`default_nettype wire

// file: sim/phml_mailbox_properties.sv
// phml_mailbox_properties: port checks for the host mailbox top
`timescale 1ns/10ps
`default_nettype none
module phml_mailbox_properties (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        tgt_req,
  input wire logic        tgt_cfg,
  input wire logic        tgt_we,
  input wire logic [31:0] tgt_addr,
  input wire logic [3:0]  tgt_be,
  input wire logic        tgt_hit,
  input wire logic        tgt_ack,
  input wire logic [31:0] tgt_rdata,
  input wire logic        host_int_req,
  input wire logic        cp_fifo_wr,
  input wire logic        cp_fifo_full,
  input wire logic        cp_data_we,
  input wire logic        cp_pdn_req,
  input wire logic        sysclk_div32,
  input wire logic        codec_master_clock_in_det,
  input wire logic        pll_sel_codec
);
  // ==========================================================
  // checks
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic tk;
  logic wr;
  logic rd0;
  assign tk = tgt_req && tgt_hit;
  assign wr = tk && !tgt_cfg && tgt_we;
  assign rd0 = tk && !tgt_cfg && !tgt_we && tgt_addr[3:2] == 2'h0;
  a_ack_after_hit: assert property (tk |=> tgt_ack)
    else $error("ack missing");
  a_no_stray_ack: assert property (!tk |=> !tgt_ack)
    else $error("stray ack");
  a_int_on_write: assert property (cp_data_we |=> host_int_req)
    else $error("irq not raised");
  a_int_clr_read: assert property
    (rd0 && tgt_be[0] && !cp_data_we |=> !host_int_req)
    else $error("irq not cleared");
  a_status_flags: assert property (rd0 |=>
    tgt_rdata[15] == !$past(host_int_req) && tgt_rdata[10:8] == 3'h0)
    else $error("status pending or zero bits wrong");
  a_full_flag: assert property
    (rd0 |=> tgt_rdata[14] == $past(cp_fifo_full))
    else $error("full flag wrong");
  a_push_write: assert property
    (wr && |tgt_be && !cp_fifo_full |=> cp_fifo_wr)
    else $error("push missing");
  a_no_push: assert property (!wr || cp_fifo_full |=> !cp_fifo_wr)
    else $error("stray push");
  a_pdn_follow: assert property (cp_pdn_req |=> sysclk_div32)
    else $error("divide by 32 missing");
  a_pll_fallback: assert property
    (!codec_master_clock_in_det [*4] |-> !pll_sel_codec)
    else $error("pll source wrong");
  c_data_read: cover property (rd0 && host_int_req);
  c_full_write: cover property (wr && cp_fifo_full);
  c_codec_sel: cover property ($rose(pll_sel_codec));
endmodule
bind phml_mailbox phml_mailbox_properties u_props (
  .clk(clk), .sys_rst(sys_rst), .tgt_req(tgt_req), .tgt_cfg(tgt_cfg),
  .tgt_we(tgt_we), .tgt_addr(tgt_addr), .tgt_be(tgt_be),
  .tgt_hit(tgt_hit), .tgt_ack(tgt_ack), .tgt_rdata(tgt_rdata),
  .host_int_req(host_int_req), .cp_fifo_wr(cp_fifo_wr),
  .cp_fifo_full(cp_fifo_full), .cp_data_we(cp_data_we),
  .cp_pdn_req(cp_pdn_req), .sysclk_div32(sysclk_div32),
  .codec_master_clock_in_det(codec_master_clock_in_det),
  .pll_sel_codec(pll_sel_codec));
`default_nettype wire

// file: sim/phml_ee_line.sv
// phml_ee_line: pulled-up serial data line with no memory fitted
`timescale 1ns/10ps
`default_nettype none
module phml_ee_line (
  input  wire logic oe_n,
  output logic      sda
);
  // absent memory never acks, so the image stays invalid
  assign sda = oe_n;
endmodule
`default_nettype wire

// file: sim/testbench.sv
// testbench: host and processor stimulus for the mailbox top
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic        clk = 0, sys_rst = 1, req = 0, cfg = 0, io = 0, we = 0;
  logic [31:0] addr = 0, wd = 0, rdata;
  logic [3:0]  be = 0;
  logic        full = 0, dwe = 0, twe = 0, pdn = 0, det = 0, sda;
  logic [7:0]  dat = 0, fwd;
  logic [2:0]  typ = 0;
  logic        ack, irq, fwr, boot, div, psel, lae, gpe, scl, oen, idv;
  logic [15:0] gpb;
  int          fail_count = 0, tests_run = 0, nb = 0;
  realtime     t0;
  phml_mailbox uut (.clk(clk), .sys_rst(sys_rst), .tgt_req(req),
    .tgt_cfg(cfg), .tgt_io(io), .tgt_we(we), .tgt_addr(addr), .tgt_be(be),
    .tgt_wdata(wd), .tgt_hit(), .tgt_ack(ack), .tgt_rdata(rdata),
    .host_int_req(irq), .cp_fifo_wr(fwr), .cp_fifo_wdata(fwd),
    .cp_fifo_full(full), .cp_data_we(dwe), .cp_data(dat), .cp_type_we(twe),
    .cp_type(typ), .cp_pdn_req(pdn), .cp_boot_rom_start(boot),
    .sysclk_div32(div), .codec_master_clock_in_det(det),
    .pll_sel_codec(psel), .legacy_audio_en(lae), .game_port_enable(gpe),
    .game_port_base(gpb), .ee_scl(scl), .ee_sda_i(sda), .ee_sda_o(),
    .ee_sda_oe_n(oen), .ee_load_busy(), .ee_id_valid(idv));
  phml_ee_line ee (.oe_n(oen), .sda(sda));
  initial forever #12.5 clk = ~clk;
  always @(posedge clk) if (boot) nb++;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one-cycle request; answer is looked at just after the ack edge
  task automatic acc(input logic c, i, w, input logic [31:0] a, d,
                     input logic [3:0] b);
    @(posedge clk); #1;
    {req, cfg, io, we, addr, wd, be} = {1'b1, c, i, w, a, d, b};
    @(posedge clk); #1;
    req = 0;
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #(25 * 20000);
    fail_count++;
    wrap_up();
  end
  initial begin
    repeat (5) @(posedge clk);
    #1 sys_rst = 0;
    acc(1, 0, 0, 32'h40, 0, 4'hF); chk(rdata[15:0], 16'h907F);
    chk({lae, gpb}, 17'h00200);
    acc(1, 0, 1, 32'h40, 32'h4, 4'h3); chk({lae, gpe}, 2'h3);
    acc(1, 0, 1, 32'h40, 32'h8004, 4'h3); chk({lae, gpe}, 2'h0);
    acc(1, 0, 0, 32'h2C, 0, 4'hF); chk(rdata, 0);
    acc(1, 0, 1, 32'h14, 32'h1000, 4'hF);
    acc(1, 0, 1, 32'h10, 32'h20000000, 4'hF);
    acc(1, 0, 1, 32'h4, 32'h3, 4'h1);
    acc(1, 0, 0, 32'h14, 0, 4'hF); chk(rdata, 32'h1001);
    $display("end config");
    acc(0, 1, 1, 32'h1004, 32'h5A00, 4'h2); chk({fwr, fwd}, 9'h15A);
    acc(0, 0, 1, 32'h2000000C, 32'h3C, 4'h1); chk({ack, fwd}, 9'h13C);
    acc(0, 1, 1, 32'h1010, 32'h1, 4'h1); chk(ack, 0);
    full = 1;
    acc(0, 1, 1, 32'h1000, 32'h77, 4'h1); chk({ack, fwr}, 2'h2);
    {dwe, twe, dat, typ} = {2'h3, 8'hA5, 3'h5};
    @(posedge clk); #1 {dwe, twe} = 2'h0;
    chk(irq, 1);
    acc(0, 1, 0, 32'h1000, 0, 4'h2); chk({irq, rdata[15:8]}, 9'h168);
    acc(0, 1, 0, 32'h1000, 0, 4'h3); chk(rdata[15:0], 16'h68A5);
    chk(irq, 0);
    full = 0;
    acc(0, 1, 0, 32'h1000, 0, 4'h2); chk(rdata[15:8], 8'hA8);
    acc(0, 1, 1, 32'h1000, 32'h10000, 4'h4);
    chk({fwr, fwd, uut.r.bb_sda, uut.r.bb_scl}, 11'h405);
    $display("end mailbox");
    det = 1;
    repeat (4) @(posedge clk);
    #1 chk(psel, 1);
    det = 0;
    repeat (4) @(posedge clk);
    #1 chk(psel, 0);
    pdn = 1;
    @(posedge clk); #1 chk(div, 1);
    chk({nb, idv}, 2'h2);
    @(posedge scl);
    @(posedge scl);
    t0 = $realtime;
    @(posedge scl);
    chk(int'(($realtime - t0) / 25.0), 1024);
    $display("end clocks");
    wrap_up();
  end
endmodule
`default_nettype wire
